//--- load_side_model.sv
/*
 Far side of the monitor: power front end and enable pin.
 Assumes the bench sets the levels; they reach the monitor on clk_sys.
*/
`timescale 1ns/1ps
module load_side_model
    import load_threshold_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Bench settings
    input wire logic [23:0] power_set,
    input wire logic enable_set,
    // Toward the monitor
    output logic [23:0] total_power = 24'h0,
    output logic threshold_enable_input = 1'b0
);
    // Measurement updated once a cycle, like a sampled front end
    always @(posedge clk_sys) begin
        total_power <= power_set;
        threshold_enable_input <= enable_set;
    end
endmodule : load_side_model

//--- load_threshold_monitor.sv
/*
 Load threshold monitor: compares total active power with two percentage
 thresholds of rated power and drives one load threshold output.
 Assumes power and rated power in the same units, enable pin asynchronous,
 and an Avalon-MM master that holds its request until waitrequest is low.
*/
// What this block does
// - Control mode bit: zero watches low power, one watches high power.
// - Monitor stays inactive unless the threshold output function is assigned.
// - With an enable input assigned, monitor runs only while it is active.
// - A disabled monitor holds the threshold output inactive.
// - After enable activation, output rests for the settling delay in seconds.
// - Lower threshold is a percentage of rated power against measured power.
// - Upper threshold is a percentage of rated power against measured power.
// - Each threshold has its own qualification delay in seconds.
// - A zero threshold or lower not below upper disables the monitor.
// - The compared quantity is total active power of the generator set.
// - Low-power mode: output set after power stays below lower for its delay.
// - Low-power mode: output cleared after power stays above upper for its delay.
// - High-power mode: output cleared after power stays below lower for its delay.
// - High-power mode: output set after power stays above upper for its delay.
`timescale 1ns/1ps
module load_threshold_monitor
    import load_threshold_pkg::*;
#(
    parameter int POWER_W = 24,
    parameter int DELAY_W = 16,
    parameter int SEC_CYCLES = CYCLES_PER_SECOND
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Measurement and pins
    input wire logic [POWER_W-1:0] total_power,
    input wire logic threshold_enable_input,
    output logic threshold_output_function,
    output logic irq
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] lower;
        logic [31:0] upper;
        logic [POWER_W-1:0] rated;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic ack;
        logic en_meta;
        logic en_sync;
        mon_state_e state;
        logic out;
        logic [31:0] tick_cnt;
        logic tick;
        logic [DELAY_W-1:0] settle_sec;
        logic [DELAY_W-1:0] low_sec;
        logic [DELAY_W-1:0] high_sec;
        logic was_valid;
    } state_s;

    state_s cur_reg, cur_next;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // Percent products kept wide: power times 100 must not wrap
    logic [POWER_W+7:0] power_pct;
    logic [POWER_W+7:0] low_lim;
    logic [POWER_W+7:0] high_lim;
    logic [7:0] lower_pct;
    logic [7:0] upper_pct;
    logic thr_valid;
    logic active;
    logic below;
    logic above;
    logic mode_high;
    logic [DELAY_W-1:0] settle_cfg;
    logic [DELAY_W-1:0] low_cfg;
    logic [DELAY_W-1:0] high_cfg;
    logic set_ev;
    logic clr_ev;

    assign lower_pct = cur_reg.lower[7:0];
    assign upper_pct = cur_reg.upper[7:0];
    assign mode_high = cur_reg.ctrl[CTRL_MODE_BIT];
    assign settle_cfg = cur_reg.ctrl[CTRL_SETTLE_LSB +: DELAY_W];
    assign low_cfg = cur_reg.lower[LOWER_DELAY_LSB +: DELAY_W];
    assign high_cfg = cur_reg.upper[UPPER_DELAY_LSB +: DELAY_W];
    assign power_pct = (POWER_W+8)'(total_power) * (POWER_W+8)'(100);
    assign low_lim = (POWER_W+8)'(cur_reg.rated) * (POWER_W+8)'(lower_pct);
    assign high_lim = (POWER_W+8)'(cur_reg.rated) * (POWER_W+8)'(upper_pct);
    assign thr_valid = (lower_pct != 8'h00) && (upper_pct != 8'h00) && (lower_pct < upper_pct);
    assign below = power_pct < low_lim;
    assign above = power_pct > high_lim;
    assign active = cur_reg.ctrl[CTRL_OUTFN_BIT] && thr_valid
                    && (!cur_reg.ctrl[CTRL_ENIN_BIT] || cur_reg.en_sync);

    always_comb begin
        cur_next = cur_reg;
        set_ev = 1'b0;
        clr_ev = 1'b0;
        cur_next.en_meta = threshold_enable_input;
        cur_next.en_sync = cur_reg.en_meta;
        // Second tick divider
        cur_next.tick = 1'b0;
        if (cur_reg.tick_cnt >= 32'(SEC_CYCLES - 1)) begin
            cur_next.tick_cnt = 32'h0000_0000;
            cur_next.tick = 1'b1;
        end else begin
            cur_next.tick_cnt = cur_reg.tick_cnt + 32'h0000_0001;
        end
        case (cur_reg.state)
            ST_IDLE: begin
                cur_next.out = 1'b0;
                cur_next.low_sec = '0;
                cur_next.high_sec = '0;
                cur_next.settle_sec = '0;
                if (active) begin
                    cur_next.state = cur_reg.ctrl[CTRL_ENIN_BIT] ? ST_SETTLE : ST_RUN;
                end
            end
            ST_SETTLE: begin
                cur_next.out = 1'b0;
                if (!active) begin
                    cur_next.state = ST_IDLE;
                end else if (cur_reg.settle_sec >= settle_cfg) begin
                    cur_next.state = ST_RUN;
                end else if (cur_reg.tick) begin
                    cur_next.settle_sec = cur_reg.settle_sec + DELAY_W'(1);
                end
            end
            ST_RUN, ST_HOLD: begin
                if (!active) begin
                    cur_next.state = ST_IDLE;
                    cur_next.out = 1'b0;
                end else begin
                    // Broken condition restarts its own timer
                    if (!below) begin
                        cur_next.low_sec = '0;
                    end else if (cur_reg.low_sec >= low_cfg) begin
                        cur_next.out = !mode_high;
                    end else if (cur_reg.tick) begin
                        cur_next.low_sec = cur_reg.low_sec + DELAY_W'(1);
                    end
                    if (!above) begin
                        cur_next.high_sec = '0;
                    end else if (cur_reg.high_sec >= high_cfg) begin
                        cur_next.out = mode_high;
                    end else if (cur_reg.tick) begin
                        cur_next.high_sec = cur_reg.high_sec + DELAY_W'(1);
                    end
                    cur_next.state = cur_next.out ? ST_HOLD : ST_RUN;
                end
            end
            default: begin
                cur_next.state = ST_IDLE;
                cur_next.out = 1'b0;
            end
        endcase
        if (cur_next.out && !cur_reg.out) begin
            set_ev = 1'b1;
        end
        if (!cur_next.out && cur_reg.out) begin
            clr_ev = 1'b1;
        end
        // Bus: one wait cycle, answer on the second edge
        cur_next.ack = (read || write) && !cur_reg.ack;
        if (read && !cur_reg.ack) begin
            case (address)
                OFF_CTRL: cur_next.rdata = cur_reg.ctrl;
                OFF_LOWER: cur_next.rdata = cur_reg.lower;
                OFF_UPPER: cur_next.rdata = cur_reg.upper;
                OFF_RATED: cur_next.rdata = 32'(cur_reg.rated);
                OFF_STATUS: cur_next.rdata = {24'h00_0000, cur_reg.state, 1'b0, cur_reg.en_sync,
                                              active, cur_reg.out};
                OFF_IRQ_STATUS: cur_next.rdata = 32'(cur_reg.irq_status);
                OFF_IRQ_MASK: cur_next.rdata = 32'(cur_reg.irq_mask);
                default: cur_next.rdata = 32'h0000_0000;
            endcase
        end
        if (write && cur_reg.ack) begin
            case (address)
                OFF_CTRL: cur_next.ctrl = merge_bytes(cur_reg.ctrl, writedata, byteenable);
                OFF_LOWER: cur_next.lower = merge_bytes(cur_reg.lower, writedata, byteenable);
                OFF_UPPER: cur_next.upper = merge_bytes(cur_reg.upper, writedata, byteenable);
                OFF_RATED: cur_next.rated = POWER_W'(merge_bytes(32'(cur_reg.rated), writedata, byteenable));
                OFF_IRQ_MASK: cur_next.irq_mask = IRQ_W'(merge_bytes(32'(cur_reg.irq_mask), writedata,
                                                                      byteenable));
                default: ;
            endcase
        end
        // Read clears status; a new event in the same cycle wins
        // Only bits the read reported are cleared; one set in the wait cycle survives
        if (read && cur_reg.ack && address == OFF_IRQ_STATUS) begin
            cur_next.irq_status = cur_reg.irq_status & ~cur_reg.rdata[IRQ_W-1:0];
        end
        if (set_ev) begin
            cur_next.irq_status[IRQ_ON_BIT] = 1'b1;
        end
        if (clr_ev) begin
            cur_next.irq_status[IRQ_OFF_BIT] = 1'b1;
        end
        if (cur_reg.was_valid && !thr_valid) begin
            cur_next.irq_status[IRQ_INVALID_BIT] = 1'b1;
        end
        cur_next.was_valid = thr_valid;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cur_reg <= '0;
            cur_reg.ctrl <= CTRL_RESET;
            cur_reg.lower <= THR_RESET;
            cur_reg.upper <= THR_RESET;
            cur_reg.rated <= POWER_W'(RATED_RESET);
            cur_reg.state <= ST_IDLE;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign readdata = cur_reg.rdata;
    assign waitrequest = (read || write) && !cur_reg.ack;
    assign threshold_output_function = cur_reg.out;
    assign irq = |(cur_reg.irq_status & cur_reg.irq_mask);

    // Steps shared by the threshold properties
    sequence run_active;
        active && cur_reg.state inside {ST_RUN, ST_HOLD};
    endsequence
    sequence low_met;
        run_active ##0 (below && cur_reg.low_sec >= low_cfg);
    endsequence
    sequence high_met;
        run_active ##0 (above && cur_reg.high_sec >= high_cfg);
    endsequence
    sequence in_band;
        run_active ##0 (!below && !above);
    endsequence

    a_disabled_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
        !active |=> ##1 !threshold_output_function)
        else $error("output high while monitor disabled");
    a_invalid_thr: assert property (@(posedge clk_sys) disable iff (!resetn)
        (lower_pct == 8'h00) |-> ##2 !threshold_output_function)
        else $error("zero lower threshold left output on");
    a_settle_rest: assert property (@(posedge clk_sys) disable iff (!resetn)
        cur_reg.state == ST_SETTLE |=> !threshold_output_function)
        else $error("output moved during settling");
    a_low_set: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cur_reg.state == ST_RUN && active && below && !mode_high && cur_reg.low_sec >= low_cfg)
        |=> threshold_output_function)
        else $error("low mode output not set");
    a_high_set: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cur_reg.state == ST_RUN && active && above && mode_high && cur_reg.high_sec >= high_cfg)
        |=> threshold_output_function)
        else $error("high mode output not set");
    // Judged one cycle on: the band must hold where the output is decided
    a_band_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        in_band |=> $stable(threshold_output_function))
        else $error("output changed inside band");
    a_timer_restart: assert property (@(posedge clk_sys) disable iff (!resetn)
        (active && !below && cur_reg.state inside {ST_RUN, ST_HOLD}) |=> cur_reg.low_sec == '0)
        else $error("lower timer not restarted");
    a_high_restart: assert property (@(posedge clk_sys) disable iff (!resetn)
        in_band |=> cur_reg.high_sec == '0)
        else $error("upper timer not restarted");
    a_enable_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cur_reg.ctrl[CTRL_ENIN_BIT] && !cur_reg.en_sync) |-> ##2 !threshold_output_function)
        else $error("output on without enable input");
    a_fn_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        !cur_reg.ctrl[CTRL_OUTFN_BIT] |-> ##2 !threshold_output_function)
        else $error("output on without output function");

    // Threshold decisions, also while the output is already held
    a_low_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
        (low_met ##0 !mode_high) |=> threshold_output_function)
        else $error("low mode output not kept");
    a_high_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
        (high_met ##0 mode_high) |=> threshold_output_function)
        else $error("high mode output not kept");
    a_low_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        (high_met ##0 !mode_high) |=> !threshold_output_function)
        else $error("low mode output not cleared");
    a_high_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        (low_met ##0 mode_high) |=> !threshold_output_function)
        else $error("high mode output not cleared");
    a_low_wait: assert property (@(posedge clk_sys) disable iff (!resetn)
        (run_active ##0 (!mode_high && !threshold_output_function && cur_reg.low_sec < low_cfg && !above))
        |=> !threshold_output_function)
        else $error("low mode output set before its delay");
    a_high_wait: assert property (@(posedge clk_sys) disable iff (!resetn)
        (run_active ##0 (mode_high && !threshold_output_function && cur_reg.high_sec < high_cfg && !below))
        |=> !threshold_output_function)
        else $error("high mode output set before its delay");

    // Settling and enable sequencing
    a_settle_early: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cur_reg.state == ST_SETTLE && cur_reg.settle_sec < settle_cfg) |=> cur_reg.state != ST_RUN)
        else $error("settling cut short");
    a_settle_done: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cur_reg.state == ST_SETTLE && active && cur_reg.settle_sec >= settle_cfg) |=> cur_reg.state == ST_RUN)
        else $error("settling did not end");
    a_settle_fresh: assert property (@(posedge clk_sys) disable iff (!resetn)
        cur_reg.state == ST_IDLE |=> cur_reg.settle_sec == '0)
        else $error("settling count not restarted");
    a_idle_settle: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cur_reg.state == ST_IDLE && active && cur_reg.ctrl[CTRL_ENIN_BIT]) |=> cur_reg.state == ST_SETTLE)
        else $error("enabled start skipped settling");
    a_idle_run: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cur_reg.state == ST_IDLE && active && !cur_reg.ctrl[CTRL_ENIN_BIT]) |=> cur_reg.state == ST_RUN)
        else $error("monitor without enable input did not run");
    a_disabled_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
        !active |=> cur_reg.state == ST_IDLE)
        else $error("disabled monitor left running");
    a_fn_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
        !cur_reg.ctrl[CTRL_OUTFN_BIT] |=> cur_reg.state == ST_IDLE)
        else $error("monitor running without output function");

    // Threshold consistency and events
    a_upper_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        (upper_pct == 8'h00) |-> ##2 !threshold_output_function)
        else $error("zero upper threshold left output on");
    a_order_thr: assert property (@(posedge clk_sys) disable iff (!resetn)
        (lower_pct >= upper_pct) |-> ##2 !threshold_output_function)
        else $error("crossed thresholds left output on");
    a_irq_invalid: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cur_reg.was_valid && !thr_valid) |=> cur_reg.irq_status[IRQ_INVALID_BIT])
        else $error("invalid threshold event lost");
    a_irq_on: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(threshold_output_function) |-> cur_reg.irq_status[IRQ_ON_BIT])
        else $error("output set event lost");
    a_irq_off: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(threshold_output_function) |-> cur_reg.irq_status[IRQ_OFF_BIT])
        else $error("output clear event lost");
endmodule : load_threshold_monitor

//--- load_threshold_monitor_bench.sv
/*
 Bench for the load threshold monitor: registers, both modes, gating.
 Assumes a one-second tick of SEC cycles and one bus wait cycle.
*/
`timescale 1ns/1ps
module load_threshold_monitor_bench
    import load_threshold_pkg::*;
;
    localparam int SEC = 10;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata;
    logic waitrequest;
    logic [23:0] power_set = 24'h0;
    logic enable_set = 1'b0;
    logic [23:0] total_power;
    logic threshold_enable_input;
    logic threshold_output_function;
    logic irq;
    logic [31:0] rd;
    int mismatches = 0;
    int samples_checked = 0;

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    load_side_model i_load_side_model (.clk_sys(clk_sys), .power_set(power_set), .enable_set(enable_set),
        .total_power(total_power), .threshold_enable_input(threshold_enable_input));
    load_threshold_monitor #(.POWER_W(24), .SEC_CYCLES(SEC)) i_load_threshold_monitor (.clk_sys(clk_sys),
        .resetn(resetn), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .total_power(total_power),
        .threshold_enable_input(threshold_enable_input),
        .threshold_output_function(threshold_output_function), .irq(irq));

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Held until waitrequest is seen low; one idle edge keeps strobes apart
    task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data);
        int n;
        address <= addr;
        writedata <= data;
        write <= wr;
        read <= !wr;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (waitrequest !== 1'b0) begin
            mismatches++;
            end_of_test();
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk_sys);
    endtask : bus

    task automatic wait_out(input logic exp, input int bound);
        int n;
        n = 0;
        while (threshold_output_function !== exp && n < bound) begin
            @(posedge clk_sys);
            n++;
        end
        check("threshold output", {31'h0, exp}, {31'h0, threshold_output_function});
        if (threshold_output_function !== exp) begin
            end_of_test();
        end
    endtask : wait_out

    task automatic hold_out(input logic exp, input int cycles);
        int bad;
        bad = 0;
        repeat (cycles) begin
            @(posedge clk_sys);
            if (threshold_output_function !== exp) begin
                bad++;
            end
        end
        check("output changes", 32'h0, bad);
    endtask : hold_out

    // Parks the monitor disabled first so every case starts from rest
    task automatic setup(input logic [31:0] ctrl, input logic [7:0] lo, input logic [7:0] hi,
                         input logic [23:0] p);
        power_set <= p;
        bus(1'b1, OFF_CTRL, 32'h0);
        bus(1'b1, OFF_RATED, 32'h3e8);
        bus(1'b1, OFF_LOWER, {8'h00, 16'h0002, lo});
        bus(1'b1, OFF_UPPER, {8'h00, 16'h0002, hi});
        bus(1'b1, OFF_CTRL, ctrl);
        bus(1'b0, OFF_IRQ_STATUS, 32'h0);
    endtask : setup

    task automatic test_regs();
        bus(1'b0, OFF_CTRL, 32'h0);
        check("ctrl reset", CTRL_RESET, rd);
        bus(1'b0, OFF_UPPER, 32'h0);
        check("upper reset", THR_RESET, rd);
        bus(1'b0, OFF_RATED, 32'h0);
        check("rated reset", RATED_RESET, rd);
        bus(1'b1, 4'hf, 32'h5a5a_5a5a);
        bus(1'b0, 4'hf, 32'h0);
        check("unmapped", 32'h0, rd);
        bus(1'b1, OFF_IRQ_MASK, 32'h7);
        bus(1'b0, OFF_IRQ_MASK, 32'h0);
        check("irq mask", 32'h7, rd);
        byteenable <= 4'h2;
        bus(1'b1, OFF_RATED, 32'hffff_ffff);
        byteenable <= 4'hf;
        bus(1'b0, OFF_RATED, 32'h0);
        check("rated lane", 32'h0000_ff00, rd);
        $display("test regs done");
    endtask : test_regs

    task automatic test_low();
        setup(32'h2, 8'h14, 8'h50, 24'h64);
        hold_out(1'b0, 8);
        wait_out(1'b1, 45);
        check("irq line", 32'h1, {31'h0, irq});
        bus(1'b0, OFF_STATUS, 32'h0);
        check("status", 32'h0000_0083, rd);
        bus(1'b0, OFF_IRQ_STATUS, 32'h0);
        check("irq status", 32'h1, rd);
        bus(1'b0, OFF_IRQ_STATUS, 32'h0);
        check("irq cleared", 32'h0, rd);
        power_set <= 24'h1f4;
        hold_out(1'b1, 40);
        power_set <= 24'h384;
        hold_out(1'b1, 8);
        wait_out(1'b0, 45);
        bus(1'b0, OFF_IRQ_STATUS, 32'h0);
        check("irq status", 32'h2, rd);
        $display("test low done");
    endtask : test_low

    task automatic test_high();
        // Lower threshold well below the shed level avoids reconnection swings
        setup(32'h3, 8'h14, 8'h50, 24'h1f4);
        hold_out(1'b0, 50);
        power_set <= 24'h384;
        hold_out(1'b0, 8);
        wait_out(1'b1, 45);
        power_set <= 24'h64;
        wait_out(1'b0, 45);
        $display("test high done");
    endtask : test_high

    task automatic test_gate();
        setup(32'h0, 8'h14, 8'h50, 24'h64);
        hold_out(1'b0, 50);
        setup(32'h2, 8'h50, 8'h14, 24'h64);
        check("irq invalid", 32'h4, rd);
        hold_out(1'b0, 50);
        setup(32'h2, 8'h00, 8'h50, 24'h64);
        hold_out(1'b0, 50);
        enable_set <= 1'b0;
        setup(32'h206, 8'h14, 8'h50, 24'h64);
        hold_out(1'b0, 50);
        enable_set <= 1'b1;
        hold_out(1'b0, 20);
        wait_out(1'b1, 70);
        enable_set <= 1'b0;
        wait_out(1'b0, 6);
        $display("test gate done");
    endtask : test_gate

    // Reset in mid-run with the output high
    task automatic test_reset();
        setup(32'h2, 8'h14, 8'h50, 24'h64);
        wait_out(1'b1, 70);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("output in reset", 32'h0, {31'h0, threshold_output_function});
        check("irq in reset", 32'h0, {31'h0, irq});
        resetn <= 1'b1;
        @(posedge clk_sys);
        bus(1'b0, OFF_CTRL, 32'h0);
        check("ctrl after reset", CTRL_RESET, rd);
        hold_out(1'b0, 30);
        $display("test reset done");
    endtask : test_reset

    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        test_regs();
        test_low();
        test_high();
        test_gate();
        test_reset();
        end_of_test();
    end
endmodule : load_threshold_monitor_bench

//--- load_threshold_pkg.sv
/*
 Constants for the load threshold monitor: register map, field layout,
 reset values and the time base. Assumes a 200 MHz system clock.
*/
package load_threshold_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int SECOND_S = 1;
    localparam int CYCLES_PER_SECOND = CLK_HZ * SECOND_S;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_LOWER = 4'h1;
    localparam logic [3:0] OFF_UPPER = 4'h2;
    localparam logic [3:0] OFF_RATED = 4'h3;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h5;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h6;
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_OUTFN_BIT = 1;
    localparam int CTRL_ENIN_BIT = 2;
    localparam int CTRL_SETTLE_LSB = 8;
    localparam int LOWER_DELAY_LSB = 8;
    localparam int UPPER_DELAY_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] THR_RESET = 32'h0000_0000;
    localparam logic [31:0] RATED_RESET = 32'h0000_0000;
    localparam int IRQ_ON_BIT = 0;
    localparam int IRQ_OFF_BIT = 1;
    localparam int IRQ_INVALID_BIT = 2;
    localparam int IRQ_W = 3;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETTLE = 4'b0010,
        ST_RUN = 4'b0100,
        ST_HOLD = 4'b1000
    } mon_state_e;
endpackage : load_threshold_pkg
